// ==== csps_pkg.sv ====
/*
  Shared constants and types of the clock switch and power save block:
  register offsets, field positions, source codes, the unlock key pair,
  and the cycle counts for the settle and wake phases.
  Assumes a 16-bit register port and a single 100 MHz system clock.
*/
package csps_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
  localparam logic [3:0] OFS_PWR_STAT = 4'h1;
  localparam logic [3:0] OFS_UNLOCK = 4'h2;

  // Field positions in osc_control_reg
  localparam int CUR_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int CFG_LOCK_BIT = 7;
  localparam int PLL_LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SEC_EN_BIT = 1;
  localparam int SW_REQ_BIT = 0;

  // Unlock key pair; the values are arbitrary
  localparam logic [15:0] UNLOCK_KEY_A = 16'h00a5;
  localparam logic [15:0] UNLOCK_KEY_B = 16'h005a;

  // Cycles of the new clock before the change-over
  localparam logic [3:0] SETTLE_CYCLES = 4'ha;
  // System clock cycles from wake to CPU restart, inside the 2 to 4 window
  localparam logic [1:0] WAKE_CYCLES = 2'h2;

  // Power save operand
  localparam logic PSAVE_SLEEP = 1'b0;
  localparam logic PSAVE_IDLE = 1'b1;

  // Primary submode codes
  localparam logic [1:0] SUBMODE_EXT_CLOCK = 2'h0;
  localparam logic [1:0] SUBMODE_CRYSTAL = 2'h1;
  localparam logic [1:0] SUBMODE_HS_CRYSTAL = 2'h2;

  // Clock source codes
  typedef enum logic [2:0] {
    SRC_FRC = 3'h0,
    SRC_FRC_PLL = 3'h1,
    SRC_PRIMARY = 3'h2,
    SRC_PRIMARY_PLL = 3'h3,
    SRC_SECONDARY = 3'h4,
    SRC_LOW_POWER_RC = 3'h5,
    SRC_FRC_DIV16 = 3'h6,
    SRC_FRC_DIVN = 3'h7
  } csps_src_t;

  localparam csps_src_t RST_SRC = SRC_FRC;

  // Configuration straps, caught once after reset
  typedef struct packed {
    logic switchEnableCfg;       // 0 enables switching
    logic monitorCfgBit;         // 0 with switching enabled runs the monitor
    logic [2:0] startupSourceCfg;
    logic [1:0] primarySubmodeCfg;
    logic watchdogEnable;
  } csps_cfg_t;

  // Oscillator enables towards the sources
  typedef struct packed {
    logic fast_internal_rc;
    logic primary;
    logic secondary;
    logic lowPowerRc;
    logic pll;
  } csps_osc_en_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT = 2'b01,
    SW_SETTLE = 2'b11,
    SW_DONE = 2'b10
  } csps_sw_state_t;

  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_IDLE = 2'b01,
    PM_WAKE = 2'b11,
    PM_SLEEP = 2'b10
  } csps_pm_state_t;

endpackage

// ==== csps_core.sv ====
/*
  Clock source switching, fail-safe fallback and Sleep/Idle control.
  Assumes all inputs are synchronous to sys_clk, newClkTick pulses once per
  cycle of the source being brought up, and the CPU issues one-cycle power
  save requests.
*/
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Switching and monitor only when enable strap zero
// - Disabled: request ignored, status shows startup source
// - Disabled: switch request ignores writes, reads zero
// - Primary submode fixed from strap at run time
// - Same source requested: clear request, abandon
// - Valid switch start clears lock and fail
// - Start oscillator, wait startup timer and PLL lock where each applies
// - Count ten new-clock cycles before change-over
// - Done: clear request, copy requested to current
// - Stop old source, keep needed low-power/secondary
// - CPU keeps running through the switch
// - Monitor on: low-power RC runs except Sleep
// - Failure raises trap, falls back to fast RC
// - Fallback keeps PLL when PLL was in use
// - Sleep stops clocks, oscillators, monitor, peripherals
// - Watchdog keeps low-power RC; cleared on entry
// - Wake on interrupt, reset or watchdog time-out
// - Sleep wake resumes on same clock source
// - Idle stops CPU, clocks and peripherals continue
// - Idle wake restarts CPU after two cycles
// - Fail flag sticky until software clears it
// - Lock bit with monitor strap freezes configuration
// - Interrupt during entry is held, then wakes
module csps_core (
  input wire logic sys_clk,                               // System clock, 100 MHz
  input wire logic rst,                                   // Asynchronous reset, active high
  input wire logic [csps_pkg::ADDR_W-1:0] regAddr,        // Register address
  input wire logic [csps_pkg::DATA_W-1:0] regWrData,      // Register write data
  input wire logic regWr,                                 // Write strobe
  input wire logic regRd,                                 // Read strobe
  output logic [csps_pkg::DATA_W-1:0] regRdData,          // Read data, cycle after strobe
  input wire csps_pkg::csps_cfg_t cfg,                    // Configuration straps
  input wire logic ostExpired,                            // Start-up timer expired
  input wire logic pllLocked,                             // PLL reports lock
  input wire logic newClkTick,                            // One pulse per new-source cycle
  input wire logic oscFail,                               // Monitor sees a dead clock
  input wire logic irqWake,                               // Enabled interrupt pending
  input wire logic wdtTimeout,                            // Watchdog time-out
  input wire logic psaveReq,                              // Power save instruction issued
  input wire logic psaveOp,                               // Operand: 0 Sleep, 1 Idle
  output logic psaveAck,                                  // Power save request accepted
  output csps_pkg::csps_osc_en_t oscEn,                   // Oscillator enables
  output csps_pkg::csps_src_t sysSrc,                     // Selected system clock source
  output logic sysClkEn,                                  // System clock running
  output logic cpuClkEn,                                  // CPU clock running
  output logic periphClkEn,                               // Peripheral clock running
  output logic failTrap,                                  // Clock failure trap pulse
  output logic wdtClear,                                  // Watchdog clear pulse
  output logic [1:0] primarySubmode                       // Fixed primary submode
);
  import csps_pkg::*;

  logic cfgLoaded_q;
  csps_cfg_t strap_q;
  csps_src_t curSrc_q;
  csps_src_t reqSrc_q;
  csps_src_t targetSrc_q;
  logic switchReq_q;
  logic cfgLock_q;
  logic pllLock_q;
  logic clockFail_q;
  logic secEnable_q;
  logic keyAOk_q;
  logic unlocked_q;
  csps_sw_state_t swState_q;
  logic [3:0] settleCnt_q;
  csps_pm_state_t pmState_q;
  logic [1:0] wakeCnt_q;
  logic irqHeld_q;
  logic [DATA_W-1:0] regRdData_q;
  csps_osc_en_t oscEn_q;
  csps_src_t sysSrc_q;
  logic sysClkEn_q;
  logic cpuClkEn_q;
  logic periphClkEn_q;
  logic failTrap_q;
  logic wdtClear_q;

  logic switchOn;
  logic monitorOn;
  logic configLocked;
  logic sleeping;
  logic failSeen;
  logic ctrlWrite;
  logic swStart;
  logic swRedundant;
  logic srcReady;
  logic pmEnter;
  logic wakeEvent;
  csps_osc_en_t oscEn_d;
  logic [DATA_W-1:0] readMux;

  // Sources that sit behind the PLL
  function automatic logic srcUsesPll(input csps_src_t src);
    return (src == SRC_FRC_PLL) || (src == SRC_PRIMARY_PLL);
  endfunction

  // Crystal sources must wait for the start-up timer; an external clock need not
  function automatic logic srcNeedsOst(input csps_src_t src, input logic [1:0] submode);
    return ((src == SRC_PRIMARY || src == SRC_PRIMARY_PLL) && submode != SUBMODE_EXT_CLOCK) ||
           (src == SRC_SECONDARY);
  endfunction

  // Oscillators that a source needs running
  function automatic csps_osc_en_t srcOscNeed(input csps_src_t src);
    csps_osc_en_t need;
    need = '0;
    need.fast_internal_rc = (src == SRC_FRC) || (src == SRC_FRC_PLL) || (src == SRC_FRC_DIV16) || (src == SRC_FRC_DIVN);
    need.primary = (src == SRC_PRIMARY) || (src == SRC_PRIMARY_PLL);
    need.secondary = (src == SRC_SECONDARY);
    need.lowPowerRc = (src == SRC_LOW_POWER_RC);
    need.pll = srcUsesPll(src);
    return need;
  endfunction

  // Mode decode from the straps; nothing acts before the straps are caught
  assign switchOn = cfgLoaded_q & ~strap_q.switchEnableCfg;
  assign monitorOn = switchOn & ~strap_q.monitorCfgBit;
  assign configLocked = cfgLock_q & strap_q.monitorCfgBit;
  assign sleeping = (pmState_q == PM_SLEEP);
  assign failSeen = monitorOn & ~sleeping & oscFail;
  assign ctrlWrite = regWr & (regAddr == OFS_OSC_CTRL) & unlocked_q & switchOn & ~configLocked;

  // Switch start decisions
  assign swRedundant = (swState_q == SW_IDLE) & switchReq_q & ~sleeping & (reqSrc_q == curSrc_q);
  assign swStart = (swState_q == SW_IDLE) & switchReq_q & ~sleeping & (reqSrc_q != curSrc_q);
  assign srcReady = (~srcNeedsOst(targetSrc_q, strap_q.primarySubmodeCfg) | ostExpired) &
                    (~srcUsesPll(targetSrc_q) | pllLocked);

  // Power save handshake and wake sources
  assign pmEnter = psaveReq & cfgLoaded_q & (pmState_q == PM_RUN);
  assign psaveAck = pmEnter;
  assign wakeEvent = irqWake | irqHeld_q | wdtTimeout;

  // Straps are caught by a clocked process after release, never by the reset itself
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfgLoaded_q <= 1'b0;
      strap_q <= '0;
    end else if (!cfgLoaded_q) begin
      cfgLoaded_q <= 1'b1;
      strap_q <= cfg;
    end
  end

  // Two-write key sequence arms exactly one write to the control register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      keyAOk_q <= 1'b0;
      unlocked_q <= 1'b0;
    end else if (regWr) begin
      keyAOk_q <= (regAddr == OFS_UNLOCK) && (regWrData == UNLOCK_KEY_A);
      unlocked_q <= (regAddr == OFS_UNLOCK) && (regWrData == UNLOCK_KEY_B) && keyAOk_q;
    end
  end

  // Software fields of the control register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reqSrc_q <= RST_SRC;
      cfgLock_q <= 1'b0;
      secEnable_q <= 1'b0;
    end else if (ctrlWrite) begin
      reqSrc_q <= csps_src_t'(regWrData[REQ_LSB +: 3]);
      cfgLock_q <= cfgLock_q | regWrData[CFG_LOCK_BIT];
      secEnable_q <= regWrData[SEC_EN_BIT];
    end
  end

  // Switch request: software sets, hardware clears; a set in the clearing cycle wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      switchReq_q <= 1'b0;
    end else if (!switchOn) begin
      switchReq_q <= 1'b0;
    end else if (ctrlWrite && regWrData[SW_REQ_BIT]) begin
      switchReq_q <= 1'b1;
    end else if (swRedundant || swState_q == SW_DONE || failSeen) begin
      switchReq_q <= 1'b0;
    end
  end

  // Switch sequencer; the CPU clock is never held here, so code runs throughout
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      swState_q <= SW_IDLE;
      settleCnt_q <= 4'h0;
      targetSrc_q <= RST_SRC;
    end else if (failSeen) begin
      swState_q <= SW_IDLE;
      settleCnt_q <= 4'h0;
    end else if (!sleeping) begin
      unique case (swState_q)
        SW_IDLE: begin
          if (swStart) begin
            swState_q <= SW_WAIT;
            targetSrc_q <= reqSrc_q;
          end
        end
        SW_WAIT: begin
          settleCnt_q <= 4'h0;
          if (srcReady) begin
            swState_q <= SW_SETTLE;
          end
        end
        SW_SETTLE: begin
          if (newClkTick) begin
            settleCnt_q <= settleCnt_q + 4'h1;
            if (settleCnt_q == SETTLE_CYCLES - 4'h1) begin
              swState_q <= SW_DONE;
            end
          end
        end
        SW_DONE: begin
          swState_q <= SW_IDLE;
        end
      endcase
    end
  end

  // Current source: startup strap while disabled, copied on completion, fallback on failure
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      curSrc_q <= RST_SRC;
    end else if (!switchOn) begin
      curSrc_q <= csps_src_t'(cfg.startupSourceCfg);
    end else if (failSeen) begin
      curSrc_q <= srcUsesPll(curSrc_q) ? SRC_FRC_PLL : SRC_FRC;
    end else if (swState_q == SW_DONE && !sleeping) begin
      curSrc_q <= targetSrc_q;
    end
  end

  // Status flags; a failure in the start cycle beats the start's clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pllLock_q <= 1'b0;
      clockFail_q <= 1'b0;
    end else begin
      if (swStart) begin
        pllLock_q <= 1'b0;
      end else begin
        pllLock_q <= pllLocked & oscEn_q.pll;
      end
      if (failSeen) begin
        clockFail_q <= 1'b1;
      end else if (swStart || (ctrlWrite && !regWrData[FAIL_BIT])) begin
        clockFail_q <= 1'b0;
      end
    end
  end

  // Power save sequencer; interrupts seen at entry are held and wake at once
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pmState_q <= PM_RUN;
      wakeCnt_q <= 2'h0;
      irqHeld_q <= 1'b0;
    end else begin
      unique case (pmState_q)
        PM_RUN: begin
          wakeCnt_q <= 2'h0;
          if (pmEnter) begin
            irqHeld_q <= irqWake;
            pmState_q <= (psaveOp == PSAVE_IDLE) ? PM_IDLE : PM_SLEEP;
          end
        end
        PM_IDLE, PM_SLEEP: begin
          if (wakeEvent) begin
            irqHeld_q <= 1'b0;
            pmState_q <= PM_WAKE;
          end
        end
        PM_WAKE: begin
          wakeCnt_q <= wakeCnt_q + 2'h1;
          if (wakeCnt_q == WAKE_CYCLES - 2'h1) begin
            pmState_q <= PM_RUN;
          end
        end
      endcase
    end
  end

  // Oscillator demand: current source, plus the target while a switch runs
  always_comb begin
    oscEn_d = srcOscNeed(curSrc_q);
    if (swState_q != SW_IDLE) begin
      oscEn_d = csps_osc_en_t'(oscEn_d | srcOscNeed(targetSrc_q));
    end
    oscEn_d.secondary = oscEn_d.secondary | secEnable_q;
    if (sleeping) begin
      oscEn_d = '0;
    end
    // With the monitor on the watchdog has no say outside Sleep
    oscEn_d.lowPowerRc = oscEn_d.lowPowerRc | (monitorOn & ~sleeping) |
                         (cfgLoaded_q & strap_q.watchdogEnable);
    if (!cfgLoaded_q) begin
      oscEn_d = '0;
    end
  end

  // Registered clock controls; curSrc survives Sleep so wake resumes on it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oscEn_q <= '0;
      sysSrc_q <= RST_SRC;
      sysClkEn_q <= 1'b0;
      cpuClkEn_q <= 1'b0;
      periphClkEn_q <= 1'b0;
    end else begin
      oscEn_q <= oscEn_d;
      sysSrc_q <= curSrc_q;
      sysClkEn_q <= cfgLoaded_q & ~sleeping;
      cpuClkEn_q <= cfgLoaded_q & (pmState_q == PM_RUN) & ~pmEnter;
      periphClkEn_q <= cfgLoaded_q & ~sleeping;
    end
  end

  // One-cycle event pulses
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      failTrap_q <= 1'b0;
      wdtClear_q <= 1'b0;
    end else begin
      failTrap_q <= failSeen;
      wdtClear_q <= pmEnter & strap_q.watchdogEnable;
    end
  end

  // Read mux; unmapped offsets and reserved bits read as zero
  always_comb begin
    readMux = '0;
    unique case (regAddr)
      OFS_OSC_CTRL: begin
        readMux[CUR_LSB +: 3] = curSrc_q;
        readMux[REQ_LSB +: 3] = reqSrc_q;
        readMux[CFG_LOCK_BIT] = cfgLock_q;
        readMux[PLL_LOCK_BIT] = pllLock_q;
        readMux[FAIL_BIT] = clockFail_q;
        readMux[SEC_EN_BIT] = secEnable_q;
        readMux[SW_REQ_BIT] = switchReq_q & switchOn;
      end
      OFS_PWR_STAT: begin
        readMux[0] = sleeping;
        readMux[1] = (pmState_q == PM_IDLE);
        readMux[2] = (pmState_q == PM_WAKE);
        readMux[3] = (swState_q != SW_IDLE);
        readMux[5:4] = swState_q;
      end
      default: begin
        readMux = '0;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData_q <= '0;
    end else begin
      regRdData_q <= regRd ? readMux : '0;
    end
  end

  assign regRdData = regRdData_q;
  assign oscEn = oscEn_q;
  assign sysSrc = sysSrc_q;
  assign sysClkEn = sysClkEn_q;
  assign cpuClkEn = cpuClkEn_q;
  assign periphClkEn = periphClkEn_q;
  assign failTrap = failTrap_q;
  assign wdtClear = wdtClear_q;
  assign primarySubmode = strap_q.primarySubmodeCfg;

endmodule

`default_nettype wire

// ==== csps_checker.sv ====
/*
  Port assertions for the clock switch and power save core.
  Assumes one clock domain and the asynchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module csps_checker
  import csps_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [3:0] regAddr, // Address
  input wire logic regRd, // Read strobe
  input wire logic [15:0] regRdData, // Read data
  input wire csps_pkg::csps_cfg_t cfg, // Straps
  input wire logic oscFail, // Failure
  input wire logic irqWake, // Interrupt
  input wire logic wdtTimeout, // Time-out
  input wire logic psaveReq, // Power save
  input wire logic psaveOp, // Operand
  input wire logic psaveAck, // Accepted
  input wire csps_pkg::csps_src_t sysSrc, // Source
  input wire logic sysClkEn, // System clock
  input wire logic cpuClkEn, // CPU clock
  input wire logic periphClkEn, // Peripheral clock
  input wire logic failTrap, // Trap
  input wire logic wdtClear, // Watchdog clear
  input wire logic [1:0] primarySubmode // Submode
);
  // One domain, so clock and reset are given once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence accepted_s;
    psaveReq && psaveAck;
  endsequence
  // Wake takes the fixed wake count plus the two state steps
  sequence restart_s;
    !cpuClkEn [*4] ##1 cpuClkEn;
  endsequence

  ack_has_req_a: assert property (psaveAck |-> psaveReq) else $error("ack without request");
  cpu_stops_a: assert property (accepted_s |=> !cpuClkEn ##1 !cpuClkEn) else $error("cpu clock kept");
  wdt_cleared_a: assert property (accepted_s ##0 cfg.watchdogEnable |=> wdtClear)
    else $error("no watchdog clear");
  sleep_off_a: assert property (accepted_s ##0 psaveOp == PSAVE_SLEEP |=> ##1 !sysClkEn && !periphClkEn)
    else $error("clocks run in sleep");
  idle_on_a: assert property (accepted_s ##0 psaveOp == PSAVE_IDLE |=> (sysClkEn && periphClkEn) [*2])
    else $error("clocks stop in idle");
  wake_time_a: assert property (!cpuClkEn [*3] ##0 $rose(irqWake || wdtTimeout) |-> restart_s)
    else $error("wake delay wrong");
  trap_cause_a: assert property (failTrap |-> $past(oscFail) &&
    !cfg.switchEnableCfg && !cfg.monitorCfgBit) else $error("trap without failure");
  trap_source_a: assert property (failTrap |-> ##[0:1]
    (sysSrc == SRC_FRC || sysSrc == SRC_FRC_PLL)) else $error("no fallback");
  fixed_source_a: assert property (cfg.switchEnableCfg [*4] |-> 3'(sysSrc) == cfg.startupSourceCfg)
    else $error("source not strap");
  req_reads_zero_a: assert property ($past(regRd) && $past(regAddr) == OFS_OSC_CTRL && cfg.switchEnableCfg
    |-> !regRdData[SW_REQ_BIT]) else $error("request bit read one");
  submode_fixed_a: assert property (!$past(rst, 2) |-> $stable(primarySubmode))
    else $error("submode changed");
endmodule

bind csps_core csps_checker u_csps_checker (.sys_clk, .rst, .regAddr, .regRd, .regRdData, .cfg, .oscFail,
  .irqWake, .wdtTimeout, .psaveReq, .psaveOp, .psaveAck, .sysSrc, .sysClkEn, .cpuClkEn, .periphClkEn,
  .failTrap, .wdtClear, .primarySubmode);
`default_nettype wire

// ==== csps_osc_model.sv ====
/*
  Oscillator sources seen from the core: start-up timer, PLL lock, ticks.
  Assumes the enables from the core are registered on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module csps_osc_model #(
  parameter int START_DELAY = 6 // Start-up cycles of crystal and PLL
) (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire csps_pkg::csps_osc_en_t oscEn, // Enables from the core
  output logic ostExpired, // Crystal started
  output logic pllLocked, // PLL locked
  output var logic newClkTick // One pulse per new cycle
);
  import csps_pkg::*;
  logic [7:0] priCnt_q;
  logic [7:0] pllCnt_q;
  // Counts restart when a source is switched off, so a restart waits again
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      priCnt_q <= 8'h00;
      pllCnt_q <= 8'h00;
    end else begin
      priCnt_q <= oscEn.primary ? priCnt_q + {7'h00, priCnt_q != 8'hff} : 8'h00;
      pllCnt_q <= oscEn.pll ? pllCnt_q + {7'h00, pllCnt_q != 8'hff} : 8'h00;
    end
  end
  // Slow new clock: a tick every other cycle, none with every source off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      newClkTick <= 1'b0;
    end else begin
      newClkTick <= !newClkTick && (|oscEn);
    end
  end
  assign ostExpired = int'(priCnt_q) >= START_DELAY;
  assign pllLocked = int'(pllCnt_q) >= START_DELAY;
endmodule
`default_nettype wire

// ==== testbench.sv ====
/*
  Self-checking bench of the clock switch and power save core.
  Assumes the oscillator model and the bound checker are compiled with it.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import csps_pkg::*;
  logic sys_clk = 1'b0;
  logic rst, regWr, regRd, ostExpired, pllLocked, newClkTick, oscFail, irqWake, wdtTimeout;
  logic psaveReq, psaveOp, psaveAck, sysClkEn, cpuClkEn, periphClkEn, failTrap, wdtClear;
  logic [3:0] regAddr;
  logic [15:0] regWrData, regRdData, d;
  logic [1:0] primarySubmode;
  csps_cfg_t cfg;
  csps_osc_en_t oscEn;
  csps_src_t sysSrc;
  int failCount = 0;
  int comparisons = 0;

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  csps_core u_csps_core (.sys_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .cfg, .ostExpired,
    .pllLocked, .newClkTick, .oscFail, .irqWake, .wdtTimeout, .psaveReq, .psaveOp, .psaveAck, .oscEn, .sysSrc,
    .sysClkEn, .cpuClkEn, .periphClkEn, .failTrap, .wdtClear, .primarySubmode);
  csps_osc_model u_csps_osc_model (.sys_clk, .rst, .oscEn, .ostExpired, .pllLocked, .newClkTick);

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic closeOut();
    if (failCount == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bus cycles; an idle cycle follows each so a strobe is never set twice in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
    @(posedge sys_clk);
  endtask

  // Unlocked control write
  task automatic ow(input logic [15:0] v);
    wr(OFS_UNLOCK, UNLOCK_KEY_A);
    wr(OFS_UNLOCK, UNLOCK_KEY_B);
    wr(OFS_OSC_CTRL, v);
  endtask

  task automatic doReset(input csps_cfg_t c);
    rst <= 1'b1;
    cfg <= c;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // Switch and wait, watching that the CPU keeps its clock
  task automatic switchTo(input logic [2:0] s);
    int n;
    logic gap;
    n = 0;
    gap = 1'b0;
    ow({5'h00, s, 8'h01});
    rd(OFS_OSC_CTRL, d);
    chk("fail at start", 16'(d[FAIL_BIT]), 16'h0000);
    while (3'(sysSrc) !== s && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (cpuClkEn !== 1'b1) gap = 1'b1;
    end
    @(posedge sys_clk);
    chk("cpu gap", 16'(gap), 16'h0000);
    chk("switch time", 16'(n > int'(SETTLE_CYCLES)), 16'h0001);
    rd(OFS_OSC_CTRL, d);
    chk("current", 16'(d[14:12]), 16'(s));
    chk("request", 16'(d[SW_REQ_BIT]), 16'h0000);
  endtask

  task automatic psave(input logic op, input logic irq);
    psaveReq <= 1'b1;
    psaveOp <= op;
    irqWake <= irq;
    #1 chk("ack", 16'(psaveAck), 16'h0001);
    @(posedge sys_clk);
    psaveReq <= 1'b0;
    irqWake <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic wake(input logic byIrq);
    int n;
    n = 0;
    irqWake <= byIrq;
    wdtTimeout <= !byIrq;
    @(posedge sys_clk);
    irqWake <= 1'b0;
    wdtTimeout <= 1'b0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (cpuClkEn !== 1'b1 && n < 20);
    @(posedge sys_clk);
    chk("wake delay", 16'(n), 16'(int'(WAKE_CYCLES) + 1));
  endtask

  task automatic failOnce(input csps_src_t s, input logic trap);
    logic seen;
    seen = 1'b0;
    oscFail <= 1'b1;
    @(posedge sys_clk);
    oscFail <= 1'b0;
    repeat (3) begin
      #1;
      if (failTrap === 1'b1) seen = 1'b1;
      @(posedge sys_clk);
    end
    chk("trap", 16'(seen), 16'(trap));
    chk("fallback", 16'(sysSrc), 16'(s));
  endtask

  // Cuts a hang short well beyond the two hundred or so cycles the tests need
  initial begin
    #200000;
    failCount++;
    closeOut();
  end

  initial begin
    rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    oscFail = 1'b0;
    irqWake = 1'b0;
    wdtTimeout = 1'b0;
    psaveReq = 1'b0;
    psaveOp = 1'b0;
    cfg = 7'h00;
    // Switching off by strap: control writes have no effect
    doReset({1'b1, 1'b1, 3'h2, SUBMODE_CRYSTAL, 1'b1});
    ow(16'h0401);
    rd(OFS_OSC_CTRL, d);
    chk("strap source", d & 16'h7001, 16'h2000);
    chk("source", 16'(sysSrc), 16'h0002);
    chk("submode", 16'(primarySubmode), 16'(SUBMODE_CRYSTAL));
    rd(4'h5, d);
    chk("unmapped", d, 16'h0000);
    // Switching, monitor and watchdog on
    doReset({1'b0, 1'b0, 3'h0, SUBMODE_CRYSTAL, 1'b1});
    ow(16'h0001);
    rd(OFS_OSC_CTRL, d);
    chk("redundant", d & 16'h0701, 16'h0000);
    wr(OFS_UNLOCK, UNLOCK_KEY_A);
    wr(OFS_OSC_CTRL, 16'h0301);
    rd(OFS_OSC_CTRL, d);
    chk("half unlock", d & 16'h0701, 16'h0000);
    switchTo(SRC_PRIMARY_PLL);
    chk("old off", 16'({oscEn.fast_internal_rc, oscEn.lowPowerRc}), 16'h0001);
    psave(PSAVE_SLEEP, 1'b0);
    #1 chk("sleep", 16'({sysClkEn, periphClkEn, cpuClkEn, oscEn.primary, oscEn.lowPowerRc}), 16'h0001);
    // Back onto the edge before driving again
    @(posedge sys_clk);
    rd(OFS_PWR_STAT, d);
    chk("sleep stat", d, 16'h0001);
    psaveReq <= 1'b1;
    #1 chk("ack asleep", 16'(psaveAck), 16'h0000);
    @(posedge sys_clk);
    psaveReq <= 1'b0;
    failOnce(SRC_PRIMARY_PLL, 1'b0);
    wake(1'b1);
    chk("resume", 16'(sysSrc), 16'(SRC_PRIMARY_PLL));
    psave(PSAVE_IDLE, 1'b0);
    #1 chk("idle", 16'({sysClkEn, periphClkEn, cpuClkEn, oscEn.lowPowerRc}), 16'h000d);
    @(posedge sys_clk);
    rd(OFS_PWR_STAT, d);
    chk("idle stat", d, 16'h0002);
    wake(1'b0);
    failOnce(SRC_FRC_PLL, 1'b1);
    rd(OFS_OSC_CTRL, d);
    chk("fail flag", 16'(d[FAIL_BIT]), 16'h0001);
    switchTo(SRC_FRC);
    failOnce(SRC_FRC, 1'b1);
    // Secondary enable set with the same write that clears the fail flag
    ow(16'h0002);
    rd(OFS_OSC_CTRL, d);
    chk("fail clear", 16'(d[FAIL_BIT]), 16'h0000);
    chk("sec kept", 16'(oscEn.secondary), 16'h0001);
    psave(PSAVE_IDLE, 1'b1);
    #1 chk("entered", 16'(cpuClkEn), 16'h0000);
    repeat (4) @(posedge sys_clk);
    #1 chk("held wake", 16'(cpuClkEn), 16'h0001);
    @(posedge sys_clk);
    // Lock honoured with the monitor strap at one; watchdog off
    doReset({1'b0, 1'b1, 3'h0, SUBMODE_EXT_CLOCK, 1'b0});
    failOnce(SRC_FRC, 1'b0);
    ow(16'h0080);
    ow(16'h0201);
    rd(OFS_OSC_CTRL, d);
    chk("locked", d & 16'h0701, 16'h0000);
    psave(PSAVE_SLEEP, 1'b0);
    #1 chk("osc off", 16'(oscEn), 16'h0000);
    @(posedge sys_clk);
    wake(1'b1);
    closeOut();
  end
endmodule
`default_nettype wire
